/* core/sswd_pkg.sv */
package sswd_pkg;
  // system clock and watchdog time base
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned WDT_UNIT_MS = 32; // watchdog_timeout_time step, ms
  localparam int unsigned WDT_UNIT_CYC = WDT_UNIT_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned WD_EARLY_CYC_DEF = 40_000;
  localparam int unsigned WD_PULSE_CYC_DEF = 400;
  localparam int unsigned WD_CW = 25;

  // register map, 5-bit serial addresses
  localparam logic [4:0] ADDR_WDOG = 5'h00;
  localparam logic [4:0] ADDR_CTRL1 = 5'h01;
  localparam logic [4:0] ADDR_CTRL2 = 5'h02;
  localparam logic [4:0] ADDR_SLEEP = 5'h03;
  localparam logic [4:0] ADDR_STAT0 = 5'h04;
  localparam int unsigned NUM_CTRL = 4;
  localparam int unsigned NUM_STAT = 4;

  // field positions
  localparam int unsigned WD_ARM_BIT = 7;
  localparam int unsigned WD_INT_LSB = 3;
  localparam int unsigned SLEEP_BIT = 6;
  localparam int unsigned CMD_DIR_BIT = 7;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [6:0] STAT_RST = 7'h00;
  localparam logic [7:0] TX_RST = 8'h00;

  // frame lengths in serial clock bits
  localparam logic [4:0] WR_FRAME_BITS = 5'h10;
  localparam logic [4:0] BIT_CNT_MAX = 5'h11;

  // frame summary held in the link domain, read by the core at frame end
  typedef struct packed {
    logic wr_first;
    logic [4:0] addr;
    logic [7:0] data;
    logic [4:0] bits;
    logic [3:0] stat_read;
  } sswd_frame_t;

  typedef logic [NUM_STAT-1:0][6:0] sswd_stat_t;
  typedef logic [NUM_CTRL-1:0][7:0] sswd_ctrl_t;

  typedef enum logic [2:0] {
    WD_OFF = 3'b001,
    WD_RUN = 3'b010,
    WD_FIRE = 3'b100
  } sswd_wd_state_t;
endpackage

/* core/sswd_spi_slave.sv */
`timescale 1ns/1ps
module sswd_spi_slave
  import sswd_pkg::*;
#(
  parameter int unsigned UNIT_CYC = WDT_UNIT_CYC,
  parameter int unsigned EARLY_CYC = WD_EARLY_CYC_DEF,
  parameter int unsigned PULSE_CYC = WD_PULSE_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic slave_serial_input,
  output logic sdo,
  output logic sdo_oe,
  input wire logic hard_clear_input,
  input wire sswd_stat_t status_set,
  output logic fault_flag_output_n,
  output logic driver_hiz,
  output logic osc_run,
  output logic [7:0] cfg_ctrl1,
  output logic [7:0] cfg_ctrl2,
  output logic reset_watchdog_output,
  output logic reset_watchdog_oe
);

  sswd_ctrl_t ctrl_reg;
  sswd_stat_t stat_reg;
  sswd_frame_t frm_reg;

  // read data for an address; status gets parity, control returned as stored
  function automatic logic [7:0] read_mux(input logic [4:0] a, input sswd_ctrl_t c, input sswd_stat_t s);
    logic [7:0] r;
    r = 8'h00;
    if (a < 5'(NUM_CTRL)) begin
      r = c[a[1:0]];
    end else if (a >= ADDR_STAT0 && a < ADDR_STAT0 + 5'(NUM_STAT)) begin
      r = {^s[a[1:0]], s[a[1:0]]};
    end
    return r;
  endfunction

  // ---------------- link domain, clocked by the master's serial clock ----------------

  // set while deselected, cleared by the first rising edge of a frame
  logic armed_reg;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  logic [2:0] bit_pos_reg;
  logic [6:0] rx_reg;
  logic expect_cmd_reg;
  logic [7:0] tx_reg;

  // decoding of the byte completing at this rising edge
  wire [2:0] bit_pos_cur = armed_reg ? 3'h0 : bit_pos_reg;
  wire [4:0] bits_cur = armed_reg ? 5'h00 : frm_reg.bits;
  wire [6:0] rx_cur = armed_reg ? 7'h00 : rx_reg;
  wire [7:0] rx_byte = {rx_cur, slave_serial_input};
  wire byte_end = (bit_pos_cur == 3'h7);
  wire is_cmd = armed_reg | expect_cmd_reg;
  wire cmd_end = byte_end & is_cmd;
  wire [4:0] addr_next = cmd_end ? rx_byte[4:0] : frm_reg.addr;
  wire stat_hit = (addr_next >= ADDR_STAT0) && (addr_next < ADDR_STAT0 + 5'(NUM_STAT));
  wire [3:0] stat_sel = stat_hit ? 4'(4'h1 << addr_next[1:0]) : 4'h0;
  wire [3:0] stat_read_base = armed_reg ? 4'h0 : frm_reg.stat_read;

  // sample on rising edges, shift in msb first
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_pos_reg <= 3'h0;
      rx_reg <= 7'h00;
      expect_cmd_reg <= 1'b1;
      frm_reg <= '0;
    end else begin
      bit_pos_reg <= 3'(bit_pos_cur + 3'h1);
      rx_reg <= rx_byte[6:0];
      frm_reg.bits <= (bits_cur == BIT_CNT_MAX) ? BIT_CNT_MAX : 5'(bits_cur + 5'h01);
      frm_reg.addr <= addr_next;
      // only a read command marks a status register for clearing; a write to one must leave it
      frm_reg.stat_read <= stat_read_base | ((cmd_end && !rx_byte[CMD_DIR_BIT]) ? stat_sel : 4'h0);
      if (byte_end) begin
        // a write command is followed by data; a read's next byte is a command
        expect_cmd_reg <= is_cmd ? ~rx_byte[CMD_DIR_BIT] : 1'b1;
      end else if (armed_reg) begin
        expect_cmd_reg <= 1'b1;
      end
      if (cmd_end && bits_cur == 5'h07) begin
        frm_reg.wr_first <= rx_byte[CMD_DIR_BIT];
      end else if (armed_reg) begin
        frm_reg.wr_first <= 1'b0;
      end
      if (byte_end && !is_cmd) begin
        frm_reg.data <= rx_byte;
      end
    end
  end

  // change output on falling edges; control and status move only while deselected or on a hard
  // clear, so the mux is stable whenever the serial clock runs and no hard clear lands
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_reg <= TX_RST;
    end else if (bit_pos_reg == 3'h0) begin
      tx_reg <= read_mux(frm_reg.addr, ctrl_reg, stat_reg);
    end else begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // output driven only while selected; never drives an idle bus
  assign sdo = tx_reg[7];
  assign sdo_oe = ~cs_n;

  // ---------------- core domain ----------------

  // chip select and hard clear cross through two flops
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic clr_s1_reg;
  logic clr_s2_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      clr_s1_reg <= 1'b0;
      clr_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      clr_s1_reg <= hard_clear_input;
      clr_s2_reg <= clr_s1_reg;
    end
  end

  wire cs_high = cs_s2_reg;
  wire cs_rise = cs_s2_reg & ~cs_s3_reg;
  wire sleep = ctrl_reg[ADDR_SLEEP[1:0]][SLEEP_BIT];
  wire clr_hit = clr_s2_reg & ~sleep; // hard clear has no effect in sleep

  // frame fields are quiet here: no serial clock while deselected
  wire wr_ok = cs_rise && frm_reg.wr_first && (frm_reg.bits == WR_FRAME_BITS);
  wire commit = wr_ok && (frm_reg.addr < 5'(NUM_CTRL));
  wire wd_rewrite = commit && (frm_reg.addr == ADDR_WDOG) && frm_reg.data[WD_ARM_BIT];

  // control registers commit only at frame end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= {NUM_CTRL{CTRL_RST}};
    end else if (clr_hit) begin
      ctrl_reg <= {NUM_CTRL{CTRL_RST}};
    end else if (commit) begin
      ctrl_reg[frm_reg.addr[1:0]] <= frm_reg.data;
    end
  end

  // status: new events win over the read clear; frozen while asleep, and while selected except on a hard clear
  wire [3:0] rd_clr = cs_rise ? frm_reg.stat_read : 4'h0;
  sswd_stat_t stat_next;
  always_comb begin
    stat_next = stat_reg;
    for (int i = 0; i < NUM_STAT; i++) begin
      if (clr_hit) begin
        stat_next[i] = STAT_RST;
      end else if (cs_high && !sleep) begin
        stat_next[i] = (rd_clr[i] ? STAT_RST : stat_reg[i]) | status_set[i];
      end
    end
  end

  logic fault_n_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_reg <= {NUM_STAT{STAT_RST}};
      fault_n_reg <= 1'b1;
    end else begin
      stat_reg <= stat_next;
      if (cs_high) begin
        fault_n_reg <= ~(|stat_next);
      end
    end
  end

  // sleep outputs; clocks wake only for a transfer
  logic hiz_reg;
  logic osc_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hiz_reg <= 1'b0;
      osc_reg <= 1'b1;
    end else begin
      hiz_reg <= sleep;
      osc_reg <= ~sleep | ~cs_high;
    end
  end

  // watchdog
  wire wd_arm = ctrl_reg[ADDR_WDOG[1:0]][WD_ARM_BIT];
  wire [3:0] wd_field = ctrl_reg[ADDR_WDOG[1:0]][WD_INT_LSB +: 4];
  wire [WD_CW-1:0] wd_limit = WD_CW'((32'(wd_field) + 32'h1) * UNIT_CYC);
  wire [WD_CW-1:0] wd_early = WD_CW'(EARLY_CYC);
  wire [WD_CW-1:0] wd_pulse = WD_CW'(PULSE_CYC);

  sswd_wd_state_t wd_state_reg;
  sswd_wd_state_t wd_state_next;
  logic [WD_CW-1:0] wd_cnt_reg;
  logic [WD_CW-1:0] wd_cnt_next;

  always_comb begin
    wd_state_next = wd_state_reg;
    wd_cnt_next = wd_cnt_reg;
    unique case (wd_state_reg)
      WD_OFF: begin
        wd_cnt_next = '0;
        if (wd_arm) begin
          wd_state_next = WD_RUN;
        end
      end
      WD_RUN: begin
        if (!wd_arm) begin
          wd_state_next = WD_OFF;
          wd_cnt_next = '0;
        end else if (wd_rewrite) begin
          wd_cnt_next = '0;
          if (wd_cnt_reg < wd_early) begin
            wd_state_next = WD_FIRE;
          end
        end else if (sleep) begin
          wd_cnt_next = wd_cnt_reg;
        end else if (wd_cnt_reg >= wd_limit - WD_CW'(1)) begin
          wd_state_next = WD_FIRE;
          wd_cnt_next = '0;
        end else begin
          wd_cnt_next = wd_cnt_reg + WD_CW'(1);
        end
      end
      WD_FIRE: begin
        if (wd_cnt_reg >= wd_pulse - WD_CW'(1)) begin
          wd_state_next = wd_arm ? WD_RUN : WD_OFF;
          wd_cnt_next = '0;
        end else begin
          wd_cnt_next = wd_cnt_reg + WD_CW'(1);
        end
      end
      default: begin
        wd_state_next = WD_OFF;
        wd_cnt_next = '0;
      end
    endcase
  end

  logic wd_oe_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_state_reg <= WD_OFF;
      wd_cnt_reg <= '0;
      wd_oe_reg <= 1'b0;
    end else if (clr_hit) begin
      wd_state_reg <= WD_OFF;
      wd_cnt_reg <= '0;
      wd_oe_reg <= 1'b0;
    end else begin
      wd_state_reg <= wd_state_next;
      wd_cnt_reg <= wd_cnt_next;
      wd_oe_reg <= (wd_state_next == WD_FIRE);
    end
  end

  // open-drain reset pin only ever pulls low
  logic wd_lvl_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_lvl_reg <= 1'b0;
    end else begin
      wd_lvl_reg <= 1'b0;
    end
  end

  assign reset_watchdog_output = wd_lvl_reg;
  assign reset_watchdog_oe = wd_oe_reg;
  assign fault_flag_output_n = fault_n_reg;
  assign driver_hiz = hiz_reg;
  assign osc_run = osc_reg;
  assign cfg_ctrl1 = ctrl_reg[ADDR_CTRL1[1:0]];
  assign cfg_ctrl2 = ctrl_reg[ADDR_CTRL2[1:0]];

  // ---------------- checks ----------------

  property p_sleep_hiz;
    @(posedge core_clk) disable iff (!arst_n)
    sleep |=> driver_hiz;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("drivers not off in sleep");

  property p_wd_hold;
    @(posedge core_clk) disable iff (!arst_n)
    (wd_state_reg == WD_RUN && sleep && wd_arm && !wd_rewrite && !clr_hit) |=> $stable(wd_cnt_reg);
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("watchdog moved in sleep");

  property p_osc_stop;
    @(posedge core_clk) disable iff (!arst_n)
    (sleep && cs_high) |=> !osc_run;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("clocks running in idle sleep");

  property p_wd_timeout;
    @(posedge core_clk) disable iff (!arst_n)
    (wd_state_reg == WD_RUN && wd_arm && !sleep && !wd_rewrite && !clr_hit && wd_cnt_reg == wd_limit - WD_CW'(1))
      |=> reset_watchdog_oe;
  endproperty
  a_wd_timeout: assert property (p_wd_timeout) else $error("no reset at timeout");

  property p_ctrl_at_cs;
    @(posedge core_clk) disable iff (!arst_n)
    ($changed(ctrl_reg) && !$past(clr_hit)) |-> $past(cs_rise) && $past(frm_reg.bits) == WR_FRAME_BITS;
  endproperty
  a_ctrl_at_cs: assert property (p_ctrl_at_cs) else $error("control changed outside a 16-bit write");

  property p_ro_write;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_ok && frm_reg.addr >= 5'(NUM_CTRL) && !clr_hit) |=> $stable(ctrl_reg);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

  property p_fault_cs;
    @(posedge core_clk) disable iff (!arst_n)
    $changed(fault_flag_output_n) |-> $past(cs_high);
  endproperty
  a_fault_cs: assert property (p_fault_cs) else $error("fault flag moved while selected");

  property p_early_fire;
    @(posedge core_clk) disable iff (!arst_n)
    (wd_state_reg == WD_RUN && wd_arm && wd_rewrite && wd_cnt_reg < wd_early && !clr_hit)
      |=> reset_watchdog_oe [*2];
  endproperty
  a_early_fire: assert property (p_early_fire) else $error("early rewrite not punished");

  property p_oe_idle;
    @(posedge core_clk) disable iff (!arst_n)
    cs_n |-> !sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");

endmodule

/* core/dummy_unused_none.sv */
`timescale 1ns/1ps

/* verif/sswd_spi_master.sv */
`timescale 1ns/1ps
// serial master; its clock stands low outside frames
module sswd_spi_master (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // pull-up holds the line high while the slave lets go
  wire miso = sdo_oe ? sdo : 1'b1;

  initial begin
    sclk = 1'b0; // idles low
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // n bits msb first, set after falling, sampled at rising
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = '0;
    #7 cs_n <= 1'b0; // only this side opens a frame
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= tx[i];
      #16 rx = {rx[22:0], miso};
      sclk <= 1'b1;
      #16 sclk <= 1'b0;
    end
    mosi <= ~mosi; // released line shows no stale bit
    #16 cs_n <= 1'b1; // idle with select high so status can update
    #150; // gap of six core cycles lets the commit land
  endtask
endmodule

/* verif/sswd_spi_slave_tb.sv */
`timescale 1ns/1ps
module sswd_spi_slave_tb
  import sswd_pkg::*;
;
  localparam int unsigned UNIT = 50;
  logic core_clk, arst_n, hard_clear_input;
  logic sclk, cs_n, mosi, sdo, sdo_oe;
  logic fault_flag_output_n, driver_hiz, osc_run;
  logic reset_watchdog_output, reset_watchdog_oe;
  logic [7:0] cfg_ctrl1, cfg_ctrl2, d;
  logic [23:0] rx;
  logic [3:0] codes [3] = '{4'h0, 4'h1, 4'hf};
  sswd_stat_t status_set;
  int miscompares = 0;
  int checks = 0;
  int cyc;

  // short watchdog unit keeps the run brief
  sswd_spi_slave #(.UNIT_CYC(UNIT), .EARLY_CYC(40), .PULSE_CYC(4)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
    .slave_serial_input(mosi), .sdo(sdo), .sdo_oe(sdo_oe),
    .hard_clear_input(hard_clear_input), .status_set(status_set),
    .fault_flag_output_n(fault_flag_output_n), .driver_hiz(driver_hiz),
    .osc_run(osc_run), .cfg_ctrl1(cfg_ctrl1), .cfg_ctrl2(cfg_ctrl2),
    .reset_watchdog_output(reset_watchdog_output), .reset_watchdog_oe(reset_watchdog_oe));

  sswd_spi_master m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .sdo(sdo), .sdo_oe(sdo_oe));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    m.xfer({8'h00, 3'b100, a, v}, 16, rx);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    m.xfer({8'h00, 3'b000, a, 8'h00}, 16, rx);
    v = rx[7:0];
  endtask

  // sampled at the falling edge, away from the flop updates
  task automatic wait_pulse(input int lim);
    cyc = 0;
    while (reset_watchdog_oe !== 1'b1 && cyc < lim) begin
      @(negedge core_clk);
      cyc++;
    end
  endtask

  task automatic pulse_in(input int lo, input int hi);
    wait_pulse(hi + 1);
    checks++;
    if (cyc < lo || cyc > hi) begin
      miscompares++;
      $display("[FAIL] pulse delay expected %0d..%0d seen %0d", lo, hi, cyc);
      if (cyc > hi)
        results();
    end
    chk("pulse level", 8'h00, {7'h0, reset_watchdog_output});
  endtask

  task automatic no_pulse(input int k);
    wait_pulse(k);
    checks++;
    if (cyc < k) begin
      miscompares++;
      $display("[FAIL] quiet watchdog expected %0d seen %0d", k, cyc);
    end
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #2_000_000;
    miscompares++;
    $display("[FAIL] run time expected below limit seen limit");
    results();
  end

  initial begin
    arst_n = 1'b0;
    hard_clear_input = 1'b0;
    status_set = '0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(5'h00, d); // first answer after power-on is thrown away
    chk("idle output enable", 8'h00, {7'h0, sdo_oe});
    // control registers reset to zero, then take a value each
    for (int a = 0; a < 4; a++) begin
      rd(5'(a), d);
      chk("ctrl reset", 8'h00, d);
      wr(5'(a), 8'h11 + 8'(a));
    end
    // a write echoes the old value of the pointed register
    for (int a = 0; a < 4; a++) begin
      wr(5'(a), 8'h21 + 8'(a));
      chk("write echo", 8'h11 + 8'(a), rx[7:0]);
    end
    chk("ctrl1 port", 8'h22, cfg_ctrl1);
    chk("ctrl2 port", 8'h23, cfg_ctrl2);
    m.xfer({8'h01, 8'h02, 8'h00}, 24, rx); // back-to-back reads in one frame
    chk("readback 01h", 8'h22, rx[15:8]);
    chk("readback 02h", 8'h23, rx[7:0]);
    // frames of wrong length are dropped whole
    m.xfer({8'h00, 16'ha15a} >> 1, 15, rx);
    m.xfer({7'h00, 16'ha15a, 1'b0}, 17, rx);
    chk("ctrl1 after bad frames", 8'h22, cfg_ctrl1);
    // 06h shares its low address bits with control 02h, so a leak would show on ctrl2
    wr(5'h06, 8'h7f);
    rd(5'h06, d);
    chk("read-only status", 8'h00, d);
    chk("ctrl2 untouched", 8'h23, cfg_ctrl2);
    // status events raised while deselected, then read and cleared
    @(posedge core_clk);
    status_set[0] <= 7'h03;
    status_set[1] <= 7'h15;
    repeat (3) @(posedge core_clk);
    status_set <= '0;
    repeat (3) @(posedge core_clk);
    chk("fault flag", 8'h00, {7'h0, fault_flag_output_n});
    wr(5'h05, 8'h00); // a write is no read, so status 1 must survive it
    chk("status 1 echo", 8'h95, rx[7:0]);
    m.xfer({8'h04, 8'h05, 8'h00}, 24, rx);
    chk("status 0", 8'h03, rx[15:8]); // even count, parity clear
    chk("status 1", 8'h95, rx[7:0]); // odd count, parity set
    rd(5'h05, d);
    chk("status cleared", 8'h00, d);
    chk("fault flag released", 8'h01, {7'h0, fault_flag_output_n});
    // timeout scales with the interval code
    foreach (codes[i]) begin
      wr(5'h00, {1'b1, codes[i], 3'b000});
      pulse_in(UNIT * (codes[i] + 1) - 10, UNIT * (codes[i] + 1) + 5);
      wr(5'h00, 8'h00);
    end
    wr(5'h00, 8'h88);
    wr(5'h00, 8'h88); // rewrite before the early window closes
    pulse_in(0, 15);
    repeat (40) @(posedge core_clk);
    wr(5'h00, 8'h88); // timely rewrite restarts the count
    no_pulse(60);
    wr(5'h00, 8'h00);
    // sleep freezes the watchdog count and the status registers
    wr(5'h00, 8'h88);
    repeat (20) @(posedge core_clk);
    wr(5'h03, 8'h40);
    chk("drivers off", 8'h01, {7'h0, driver_hiz});
    no_pulse(200);
    // an event raised during sleep must not reach the status registers
    @(posedge core_clk);
    status_set[2] <= 7'h01;
    repeat (3) @(posedge core_clk);
    status_set <= '0;
    repeat (3) @(posedge core_clk);
    chk("status frozen asleep", 8'h01, {7'h0, fault_flag_output_n});
    chk("clocks stopped", 8'h00, {7'h0, osc_run});
    chk("ctrl kept", 8'h22, cfg_ctrl1);
    wr(5'h03, 8'h00); // wake
    chk("drivers back", 8'h00, {7'h0, driver_hiz});
    chk("clocks back", 8'h01, {7'h0, osc_run});
    pulse_in(20, 70); // resumes from the held count
    wr(5'h00, 8'h00);
    @(posedge core_clk);
    hard_clear_input <= 1'b1;
    repeat (6) @(posedge core_clk);
    hard_clear_input <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("cleared ctrl1", 8'h00, cfg_ctrl1);
    chk("cleared ctrl2", 8'h00, cfg_ctrl2);
    results();
  end
endmodule
